// >>> core/pfpe_pkg.sv
package pfpe_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned PD_FILT_T1_S = 4;
  localparam longint unsigned PD_FILT_T2_S = 129;
  localparam longint unsigned PD_FILT_T3_S = 518;
  localparam longint unsigned PD_FILT_T3_IRQ_S = 515;
  localparam int FILT_W = 36;
  localparam logic [FILT_W-1:0] PD_FILT_T1_CYC =
    FILT_W'(PD_FILT_T1_S * CLK_HZ);
  localparam logic [FILT_W-1:0] PD_FILT_T2_CYC =
    FILT_W'(PD_FILT_T2_S * CLK_HZ);
  localparam logic [FILT_W-1:0] PD_FILT_T3_CYC =
    FILT_W'(PD_FILT_T3_S * CLK_HZ);
  localparam logic [FILT_W-1:0] PD_FILT_T3_IRQ_CYC =
    FILT_W'(PD_FILT_T3_IRQ_S * CLK_HZ);

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PMCSR0_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PMCSR1_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] PIN_CFG_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] LOCAL_CTL_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] GLB_IRQ_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] PM_CAP_OFS = 8'h14;

  // pmcsr fields
  localparam int PM_STATE_LSB = 0;
  localparam int PME_EN_BIT = 8;
  localparam int PME_ST_BIT = 15;
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  // pin config fields
  localparam int WAKE_SEL_LSB = 4;
  localparam int PIN_SENSE_LSB = 16;
  localparam logic [1:0] WAKE_RISE = 2'h0;
  localparam logic [1:0] WAKE_FALL = 2'h1;
  // local control fields
  localparam int FILT_SEL_LSB = 5;
  localparam int WAKE_EN_BIT = 7;
  // global irq fields
  localparam int F0_PD_ST_BIT = 5;
  localparam int F1_PD_ST_BIT = 6;
  localparam int GLB_EN_BIT = 21;
  localparam int F1_PD_IRQ_BIT = 22;
  localparam int F1_PIN_B_BIT = 23;
  localparam int PD_PIN_EN_LSB = 24;
  localparam logic [31:0] GLB_RW_MASK = 32'hffe0_0000;
  // capability fields
  localparam int CAP_D3COLD_BIT = 15;
  localparam logic [31:0] PM_CAP_BASE = 32'h6602_0000;
  localparam logic [31:0] PM_CAP_BASE_LO = 32'h0000_6000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] pstate;
    logic pme_en;
    logic pme_st;
  } pfpe_pm_t;

  typedef struct packed {
    logic aw_v;
    logic [ADDR_W-1:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pfpe_bus_t;

endpackage

// >>> core/pfpe_top.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// - pins 10..3 may request function-1 power-down; only pin 2 wakes it.
// - each power-down pin's active level comes from the pin config register.
// - power-down request follows an enabled active pin without filtering.
// - with the option set, power-down request drives function 1 interrupt.
// - power state changes only by host write; host arms wake-up first.
// - function 1 in D2 or D3 puts parallel port and local bus low-power.
// - a function in D2 or D3 has its interrupts blocked regardless of masks.
// - a function in D2 or D3 refuses BAR accesses; config space still works.
// - function 1 wake-up events occur only while its PME_En is set.
// - wake-up asserts on the third clock edge after pin 2 shows the configured edge.
// - PME_Status sets on wake-up and clears only on host write of one.
// - PME# asserts while PME_Status and PME_En are both set.
// - filter setting 00: power-down irq off, pin 1 irq if bit 21 set.
// - nonzero setting, bit 21 clear: no pin 1 or function 0 power-down irq, status bit 5 shows state.
// - nonzero setting, bit 21 set: power-down irq on, 11 means 515 s.
// - wake enable clear: no change; edge select 00 rising, 01 falling.
// - mode input high selects miniPCI, low selects standard PCI.
// - pin A serves both functions unless bit 23 moves function 1 to pin B in standard PCI; pin B is CLKRUN# in miniPCI.
// - PME# from D3cold advertised and supported only in miniPCI mode.
module pfpe_top #(
  parameter int PINS = 11,
  parameter logic [35:0] FILT_T1_CYC = pfpe_pkg::PD_FILT_T1_CYC,
  parameter logic [35:0] FILT_T2_CYC = pfpe_pkg::PD_FILT_T2_CYC,
  parameter logic [35:0] FILT_T3_CYC = pfpe_pkg::PD_FILT_T3_CYC,
  parameter logic [35:0] FILT_T3_IRQ_CYC = pfpe_pkg::PD_FILT_T3_IRQ_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [pfpe_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pfpe_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device side
  input wire logic [PINS-1:0] multi_purpose_pin,
  input wire logic mini_pci_sel,
  input wire logic f0_uart_idle,
  input wire logic f0_wake_req,
  input wire logic f0_irq_src,
  input wire logic f1_irq_src,
  output logic irq_pin_a_n,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe_n,
  output logic pme_n_o,
  output logic pme_oe_n,
  output logic f0_low_power,
  output logic f1_low_power,
  output logic f0_bar_en,
  output logic f1_bar_en
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // pin roles below are fixed to the eleven-pin map
  if (PINS != 11) begin : g_bad_pins
    $error("pfpe_top: pin count must be 11");
  end
  // a zero limit would wrap the filter compare to the all-ones count
  if (FILT_T1_CYC == 36'h0_0000_0000) begin : g_bad_t1
    $error("pfpe_top: first filter limit must be non-zero");
  end
  if (FILT_T2_CYC == 36'h0_0000_0000) begin : g_bad_t2
    $error("pfpe_top: second filter limit must be non-zero");
  end
  if (FILT_T3_CYC == 36'h0_0000_0000) begin : g_bad_t3
    $error("pfpe_top: third filter limit must be non-zero");
  end
  if (FILT_T3_IRQ_CYC == 36'h0_0000_0000) begin : g_bad_t3_irq
    $error("pfpe_top: third interrupt filter limit must be non-zero");
  end

  // ****************************************************************
  // pin roles and filter selects
  // ****************************************************************
  localparam int IRQ_PIN = 1;
  localparam int WAKE_PIN = 2;
  localparam int PD_PIN_LO = 3;
  localparam int PD_PINS = 8;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_SHORT = 2'h1;
  localparam logic [1:0] FILT_MID = 2'h2;
  localparam logic [1:0] FILT_LONG = 2'h3;

  typedef struct packed {
    pfpe_pkg::pfpe_bus_t bus;
    pfpe_pkg::pfpe_pm_t [1:0] pm;
    logic [31:0] pin_cfg;
    logic [31:0] local_ctl;
    logic [31:0] glb_ctl;
    logic [PINS-1:0] sync1;
    logic [PINS-1:0] sync2;
    logic pin2_prev;
    logic [35:0] filt_cnt;
    logic f0_pd;
    logic irq_a;
    logic irq_b;
    logic pme;
    logic [1:0] low_pwr;
  } pfpe_state_t;

  pfpe_state_t s_q;
  pfpe_state_t s_d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] pm_word(input pfpe_pkg::pfpe_pm_t p);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[pfpe_pkg::PM_STATE_LSB +: 2] = p.pstate;
    r[pfpe_pkg::PME_EN_BIT] = p.pme_en;
    r[pfpe_pkg::PME_ST_BIT] = p.pme_st;
    return r;
  endfunction

  // ****************************************************************
  // combinational decode
  // ****************************************************************
  logic [PINS-1:0] pin_active;
  logic [1:0] filt_sel;
  logic glb_en;
  logic f1_pd_req;
  logic pin1_irq;
  logic f0_pd_irq;
  logic f0_irq;
  logic f1_irq;
  logic pin2_rise;
  logic pin2_fall;
  logic f1_wake;
  logic f0_wake;
  logic [35:0] filt_lim;
  logic wr_go;
  logic rd_go;
  logic [31:0] gis_rd;
  logic [31:0] cap_rd;

  always_comb begin
    // active level per pin, level bit high means active high
    pin_active = ~(s_q.sync2 ^
      s_q.pin_cfg[pfpe_pkg::PIN_SENSE_LSB +: PINS]);
    filt_sel = s_q.local_ctl[pfpe_pkg::FILT_SEL_LSB +: 2];
    glb_en = s_q.glb_ctl[pfpe_pkg::GLB_EN_BIT];
    // no filter on function 1 power-down
    f1_pd_req = |(pin_active[PD_PIN_LO +: PD_PINS] &
      s_q.glb_ctl[pfpe_pkg::PD_PIN_EN_LSB +: PD_PINS]);
    // a running filter takes pin 1 off the interrupt
    pin1_irq = (filt_sel == FILT_OFF) && glb_en &&
      pin_active[IRQ_PIN];
    f0_pd_irq = (filt_sel != FILT_OFF) && glb_en && s_q.f0_pd;
    // low-power states block interrupts regardless of masks
    f0_irq = (f0_irq_src || pin1_irq || f0_pd_irq) &&
      !s_q.low_pwr[0];
    f1_irq = (f1_irq_src ||
      (f1_pd_req && s_q.glb_ctl[pfpe_pkg::F1_PD_IRQ_BIT])) &&
      !s_q.low_pwr[1];
    pin2_rise = s_q.sync2[WAKE_PIN] && !s_q.pin2_prev;
    pin2_fall = !s_q.sync2[WAKE_PIN] && s_q.pin2_prev;
    f1_wake = 1'b0;
    if (s_q.local_ctl[pfpe_pkg::WAKE_EN_BIT] && s_q.pm[1].pme_en) begin
      case (s_q.pin_cfg[pfpe_pkg::WAKE_SEL_LSB +: 2])
        pfpe_pkg::WAKE_RISE: f1_wake = pin2_rise;
        pfpe_pkg::WAKE_FALL: f1_wake = pin2_fall;
        default: f1_wake = 1'b0;
      endcase
    end
    f0_wake = f0_wake_req && s_q.pm[0].pme_en;
    case (filt_sel)
      FILT_SHORT: filt_lim = FILT_T1_CYC;
      FILT_MID: filt_lim = FILT_T2_CYC;
      FILT_LONG: filt_lim = glb_en ? FILT_T3_IRQ_CYC : FILT_T3_CYC;
      default: filt_lim = 36'h0_0000_0000;
    endcase
    gis_rd = s_q.glb_ctl & pfpe_pkg::GLB_RW_MASK;
    gis_rd[pfpe_pkg::F0_PD_ST_BIT] =
      (filt_sel != FILT_OFF) && s_q.f0_pd;
    gis_rd[pfpe_pkg::F1_PD_ST_BIT] = f1_pd_req;
    cap_rd = pfpe_pkg::PM_CAP_BASE;
    cap_rd[pfpe_pkg::CAP_D3COLD_BIT] = mini_pci_sel;
    wr_go = s_q.bus.aw_v && s_q.bus.w_v && !s_q.bus.bvalid;
    rd_go = s_axi_arvalid && !s_q.bus.rvalid;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0] wv;
    logic [31:0] pw;
    wv = 32'h0000_0000;
    pw = 32'h0000_0000;
    s_d = s_q;
    s_d.sync1 = multi_purpose_pin;
    s_d.sync2 = s_q.sync1;
    s_d.pin2_prev = s_q.sync2[WAKE_PIN];

    // function 0 power-down filter; any activity restarts the wait
    if (!f0_uart_idle || filt_sel == FILT_OFF) begin
      s_d.filt_cnt = 36'h0_0000_0000;
      s_d.f0_pd = 1'b0;
    end else if (s_q.filt_cnt >= filt_lim - 36'h0_0000_0001) begin
      s_d.f0_pd = 1'b1;
    end else begin
      s_d.filt_cnt = s_q.filt_cnt + 36'h0_0000_0001;
    end

    // axi write channel
    if (s_axi_awvalid && !s_q.bus.aw_v) begin
      s_d.bus.aw_v = 1'b1;
      s_d.bus.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.bus.w_v) begin
      s_d.bus.w_v = 1'b1;
      s_d.bus.w_data = s_axi_wdata;
      s_d.bus.w_strb = s_axi_wstrb;
    end
    if (s_q.bus.bvalid && s_axi_bready) begin
      s_d.bus.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_d.bus.aw_v = 1'b0;
      s_d.bus.w_v = 1'b0;
      s_d.bus.bvalid = 1'b1;
      s_d.bus.bresp = pfpe_pkg::RESP_OKAY;
      case (s_q.bus.aw_addr)
        pfpe_pkg::PMCSR0_OFS, pfpe_pkg::PMCSR1_OFS: begin
          for (int f = 0; f < 2; f++) begin
            if (s_q.bus.aw_addr[2] == f[0]) begin
              pw = pm_word(s_q.pm[f]);
              wv = merge(pw, s_q.bus.w_data, s_q.bus.w_strb);
              // only host writes move the power state; D1 unsupported
              if (wv[pfpe_pkg::PM_STATE_LSB +: 2] != pfpe_pkg::PS_D1) begin
                s_d.pm[f].pstate = wv[pfpe_pkg::PM_STATE_LSB +: 2];
              end
              s_d.pm[f].pme_en = wv[pfpe_pkg::PME_EN_BIT];
              // write one clears; zero leaves it
              if (s_q.bus.w_strb[1] &&
                  s_q.bus.w_data[pfpe_pkg::PME_ST_BIT]) begin
                s_d.pm[f].pme_st = 1'b0;
              end
            end
          end
        end
        pfpe_pkg::PIN_CFG_OFS:
          s_d.pin_cfg = merge(s_q.pin_cfg, s_q.bus.w_data, s_q.bus.w_strb);
        pfpe_pkg::LOCAL_CTL_OFS:
          s_d.local_ctl = merge(s_q.local_ctl, s_q.bus.w_data,
            s_q.bus.w_strb);
        pfpe_pkg::GLB_IRQ_OFS:
          s_d.glb_ctl = merge(s_q.glb_ctl, s_q.bus.w_data, s_q.bus.w_strb) &
            pfpe_pkg::GLB_RW_MASK;
        pfpe_pkg::PM_CAP_OFS: ;
        default: s_d.bus.bresp = pfpe_pkg::RESP_SLVERR;
      endcase
    end

    // wake-up sets status after any clear so the set wins
    if (f0_wake) begin
      s_d.pm[0].pme_st = 1'b1;
    end
    if (f1_wake) begin
      s_d.pm[1].pme_st = 1'b1;
    end

    // axi read channel
    if (s_q.bus.rvalid && s_axi_rready) begin
      s_d.bus.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_d.bus.rvalid = 1'b1;
      s_d.bus.rresp = pfpe_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pfpe_pkg::PMCSR0_OFS: s_d.bus.rdata = pm_word(s_q.pm[0]);
        pfpe_pkg::PMCSR1_OFS: s_d.bus.rdata = pm_word(s_q.pm[1]);
        pfpe_pkg::PIN_CFG_OFS: s_d.bus.rdata = s_q.pin_cfg;
        pfpe_pkg::LOCAL_CTL_OFS: s_d.bus.rdata = s_q.local_ctl;
        pfpe_pkg::GLB_IRQ_OFS: s_d.bus.rdata = gis_rd;
        pfpe_pkg::PM_CAP_OFS: s_d.bus.rdata = cap_rd;
        default: begin
          s_d.bus.rdata = 32'h0000_0000;
          s_d.bus.rresp = pfpe_pkg::RESP_SLVERR;
        end
      endcase
    end

    // outputs
    for (int f = 0; f < 2; f++) begin
      s_d.low_pwr[f] = s_d.pm[f].pstate[1];
    end
    s_d.pme = (s_d.pm[0].pme_st && s_d.pm[0].pme_en) ||
      (s_d.pm[1].pme_st && s_d.pm[1].pme_en);
    if (mini_pci_sel) begin
      s_d.irq_a = f0_irq || f1_irq;
      s_d.irq_b = 1'b0;
    end else if (s_q.glb_ctl[pfpe_pkg::F1_PIN_B_BIT]) begin
      s_d.irq_a = f0_irq;
      s_d.irq_b = f1_irq;
    end else begin
      s_d.irq_a = f0_irq || f1_irq;
      s_d.irq_b = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // ports
  // ****************************************************************
  assign s_axi_awready = !s_q.bus.aw_v;
  assign s_axi_wready = !s_q.bus.w_v;
  assign s_axi_bvalid = s_q.bus.bvalid;
  assign s_axi_bresp = s_q.bus.bresp;
  assign s_axi_arready = !s_q.bus.rvalid;
  assign s_axi_rvalid = s_q.bus.rvalid;
  assign s_axi_rdata = s_q.bus.rdata;
  assign s_axi_rresp = s_q.bus.rresp;
  assign irq_pin_a_n = !s_q.irq_a;
  // pin b is open drain; in miniPCI it belongs to clock-run logic
  assign irq_pin_b_o = 1'b0;
  assign irq_pin_b_oe_n = !s_q.irq_b;
  assign pme_n_o = 1'b0;
  assign pme_oe_n = !s_q.pme;
  assign f0_low_power = s_q.low_pwr[0];
  assign f1_low_power = s_q.low_pwr[1];
  assign f0_bar_en = !s_q.low_pwr[0];
  assign f1_bar_en = !s_q.low_pwr[1];

endmodule

// >>> test/pfpe_host_model.sv
`timescale 1ns/1ps
// ********
// host driver model
// ********
module pfpe_host_model (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic host_stall
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, host_stall, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
  end
  // power state only ever moves through these host writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) host_stall <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) host_stall <= 1'b1;
  endtask
endmodule

// >>> test/pfpe_props.sv
`timescale 1ns/1ps
// ********
// port checks
// ********
module pfpe_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mini_pci_sel,
  input wire logic irq_pin_a_n,
  input wire logic irq_pin_b_o,
  input wire logic irq_pin_b_oe_n,
  input wire logic pme_n_o,
  input wire logic pme_oe_n,
  input wire logic f0_low_power,
  input wire logic f1_low_power,
  input wire logic f0_bar_en,
  input wire logic f1_bar_en
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  f1_gate_a: assert property (f1_low_power == !f1_bar_en)
    else $error("f1 gating mismatch");
  f0_gate_a: assert property (f0_low_power == !f0_bar_en)
    else $error("f0 gating mismatch");
  irq_block_a: assert property ((f0_low_power && f1_low_power)[*2]
    |-> irq_pin_a_n) else $error("irq while both asleep");
  pin_b_mini_a: assert property (mini_pci_sel[*2] |-> irq_pin_b_oe_n)
    else $error("pin b driven in mini mode");
  open_drain_a: assert property (!pme_n_o && !irq_pin_b_o)
    else $error("open drain level wrong");
  b_pending_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write answer held after handshake");
  r_pending_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer held after handshake");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  pme_cov: cover property (!pme_oe_n);
  sleep_cov: cover property (f0_low_power && f1_low_power);
  wresp_cov: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind pfpe_top pfpe_props u_props (.clk_sys, .sys_rst, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .mini_pci_sel, .irq_pin_a_n, .irq_pin_b_o, .irq_pin_b_oe_n, .pme_n_o,
  .pme_oe_n, .f0_low_power, .f1_low_power, .f0_bar_en, .f1_bar_en);

// >>> test/testbench.sv
`timescale 1ns/1ps
// ********
// bench
// ********
module testbench;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [31:0] rdata;
  } pfpe_row_t;
  logic clk_sys, sys_rst, mini_pci_sel, f0_uart_idle, f0_wake_req;
  logic f0_irq_src, f1_irq_src, irq_pin_a_n, irq_pin_b_o, irq_pin_b_oe_n;
  logic pme_n_o, pme_oe_n, f0_low_power, f1_low_power, f0_bar_en;
  logic f1_bar_en, host_stall, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [10:0] multi_purpose_pin;
  int mismatches = 0;
  int samples_checked = 0;
  pfpe_row_t rows [6] = '{
    '{8'h08, 32'h0000_0010, 2'h0, 32'h0000_0010},
    '{8'h0c, 32'h0000_0080, 2'h0, 32'h0000_0080},
    '{8'h10, 32'h0020_0000, 2'h0, 32'h0020_0000},
    '{8'h14, 32'hffff_ffff, 2'h0, 32'h6602_8000},
    '{8'h18, 32'h0000_1234, 2'h2, 32'h0000_0000},
    '{8'h00, 32'h0000_0001, 2'h0, 32'h0000_0000}};

  pfpe_top #(.FILT_T1_CYC(36'h8), .FILT_T2_CYC(36'h10), .FILT_T3_CYC(36'h20),
    .FILT_T3_IRQ_CYC(36'h1e)) dut (.clk_sys, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .multi_purpose_pin, .mini_pci_sel, .f0_uart_idle,
    .f0_wake_req, .f0_irq_src, .f1_irq_src, .irq_pin_a_n, .irq_pin_b_o,
    .irq_pin_b_oe_n, .pme_n_o, .pme_oe_n, .f0_low_power, .f1_low_power,
    .f0_bar_en, .f1_bar_en);
  pfpe_host_model host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_stall);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, rd_v, rsp);
    chk(rd_v, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.wr(a, d, rsp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic toggle2();
    multi_purpose_pin[2] <= 1'b1;
    tick(6);
    multi_purpose_pin[2] <= 1'b0;
    tick(6);
  endtask
  task automatic test_done();
    $display("compares %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge host_stall) begin
    mismatches++;
    test_done();
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {sys_rst, mini_pci_sel, f0_uart_idle, f0_wake_req} = 4'hc;
    {f0_irq_src, f1_irq_src, multi_purpose_pin} = 13'h0;
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
    chk(32'({irq_pin_a_n, pme_oe_n, f1_low_power, f1_bar_en}), 32'hd);
    $display("reset test done");
    foreach (rows[i]) begin
      host.wr(rows[i].addr, rows[i].wdata, rsp);
      chk(32'(rsp), 32'(rows[i].resp));
      rc(rows[i].addr, rows[i].rdata);
      chk(32'(rsp), 32'(rows[i].resp));
    end
    $display("register table done");
    // pins 3 and 1 active high, pin 3 may request power-down
    wr(8'h08, 32'h000a_0000);
    wr(8'h10, 32'h0160_0000);
    tick(4);
    chk(32'(irq_pin_a_n), 32'h1);
    multi_purpose_pin[3] <= 1'b1;
    tick(5);
    chk(32'(irq_pin_a_n), 32'h0);
    rc(8'h10, 32'h0160_0040);
    multi_purpose_pin[3] <= 1'b0;
    tick(5);
    chk(32'(irq_pin_a_n), 32'h1);
    $display("power-down request test done");
    wr(8'h04, 32'h0000_0100);
    multi_purpose_pin[2] <= 1'b1;
    tick(6);
    chk(32'(pme_oe_n), 32'h0);
    wr(8'h04, 32'h0000_0100);
    rc(8'h04, 32'h0000_8100);
    wr(8'h04, 32'h0000_8100);
    rc(8'h04, 32'h0000_0100);
    chk(32'(pme_oe_n), 32'h1);
    wr(8'h08, 32'h000a_0010);
    multi_purpose_pin[2] <= 1'b0;
    tick(6);
    rc(8'h04, 32'h0000_8100);
    wr(8'h04, 32'h0000_8000);
    toggle2();
    rc(8'h04, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0000);
    wr(8'h04, 32'h0000_0100);
    toggle2();
    rc(8'h04, 32'h0000_0100);
    $display("wake-up test done");
    f1_irq_src <= 1'b1;
    tick(4);
    chk(32'(irq_pin_a_n), 32'h0);
    wr(8'h04, 32'h0000_0003);
    tick(3);
    chk(32'({f1_low_power, f1_bar_en, irq_pin_a_n}), 32'h5);
    rc(8'h04, 32'h0000_0003);
    wr(8'h00, 32'h0000_0002);
    tick(3);
    chk(32'({f0_low_power, f0_bar_en}), 32'h2);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    $display("low-power test done");
    wr(8'h10, 32'h00a0_0000);
    tick(3);
    chk(32'(irq_pin_b_oe_n), 32'h1);
    mini_pci_sel <= 1'b0;
    tick(3);
    chk(32'(irq_pin_b_oe_n), 32'h0);
    rc(8'h14, 32'h6602_0000);
    f1_irq_src <= 1'b0;
    multi_purpose_pin[1] <= 1'b1;
    tick(4);
    chk(32'(irq_pin_a_n), 32'h0);
    $display("mode test done");
    f0_uart_idle <= 1'b1;
    wr(8'h10, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0020);
    tick(12);
    rc(8'h10, 32'h0000_0020);
    chk(32'(irq_pin_a_n), 32'h1);
    wr(8'h10, 32'h0020_0000);
    tick(3);
    chk(32'(irq_pin_a_n), 32'h0);
    // longest select with the interrupt on: limit 0x1e, not 0x20
    f0_uart_idle <= 1'b0;
    wr(8'h0c, 32'h0000_0060);
    f0_uart_idle <= 1'b1;
    tick(29);
    chk(32'(irq_pin_a_n), 32'h1);
    tick(3);
    chk(32'(irq_pin_a_n), 32'h0);
    $display("filter test done");
    // function 0 wake source, held high across a status clear
    wr(8'h00, 32'h0000_0100);
    f0_wake_req <= 1'b1;
    wr(8'h00, 32'h0000_8100);
    rc(8'h00, 32'h0000_8100);
    chk(32'(pme_oe_n), 32'h0);
    f0_wake_req <= 1'b0;
    wr(8'h00, 32'h0000_8100);
    rc(8'h00, 32'h0000_0100);
    chk(32'(pme_oe_n), 32'h1);
    $display("function 0 wake test done");
    test_done();
  end
endmodule
